// >>> design/fpo_params.svh
/*
  Constants for the fixed-point primitive datapath: widths, limits,
  reset values and the fixed latency.
  Assumes inclusion by bare name from the design modules only.
*/
`ifndef FPO_PARAMS_SVH
`define FPO_PARAMS_SVH

`define FPO_WORD_W    32
`define FPO_LONG_W    40
`define FPO_HALF_W    16
`define FPO_CST_W     5
`define FPO_AMT_W     6
`define FPO_CNT_W     6
`define FPO_CREG_NONE 3'h0
`define FPO_WORD_MAX  40'h007FFFFFFF
`define FPO_WORD_MIN  40'h0080000000
`define FPO_LONG_MAX  40'h7FFFFFFFFF
`define FPO_LONG_MIN  40'h8000000000
`define FPO_RST_RES   40'h0000000000
`define FPO_LATENCY   1

`endif

// >>> design/fpo_pkg.sv
/*
  Types of the fixed-point primitive datapath: operation codes, operand
  sources, address mode entry, request, response and module state.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fpo_pkg;

  typedef enum logic [4:0] {
    OP_ADD                  = 5'h00,
    OP_SUB                  = 5'h01,
    OP_SADD                 = 5'h02,
    OP_SSUB                 = 5'h03,
    OP_ADDA                 = 5'h04,
    OP_SUBA                 = 5'h05,
    OP_AND                  = 5'h06,
    OP_OR                   = 5'h07,
    OP_XOR                  = 5'h08,
    OP_NOT                  = 5'h09,
    OP_ABS                  = 5'h0A,
    OP_CLR                  = 5'h0B,
    OP_SET                  = 5'h0C,
    OP_EXT                  = 5'h0D,
    OP_EXTU                 = 5'h0E,
    OP_SHL                  = 5'h0F,
    OP_SHR                  = 5'h10,
    OP_SHRU                 = 5'h11,
    OP_LEFTMOST_ZERO_SEARCH = 5'h12,
    OP_LEFTMOST_ONE_SEARCH  = 5'h13,
    OP_NORM                 = 5'h14,
    OP_MV                   = 5'h15
  } fpo_op_e;

  typedef enum logic [1:0] {
    SRC_REG  = 2'h0,
    SRC_HALF = 2'h1,
    SRC_CST  = 2'h2
  } fpo_src_e;

  typedef enum logic [0:0] {
    AM_LINEAR = 1'h0,
    AM_CIRC   = 1'h1
  } fpo_am_e;

  // Address mode entry for the base register of an address operation
  typedef struct packed {
    fpo_am_e    mode;
    logic [4:0] blk;
  } fpo_amr_s;

  typedef struct packed {
    logic        valid;
    fpo_op_e     op;
    logic        long_op;
    logic [39:0] src1;
    logic [39:0] own2;
    logic [39:0] cross2;
    logic        use_cross;
    fpo_src_e    src2;
    logic        half_hi;
    logic        half_sgn;
    logic [4:0]  cst;
    logic        cst_sgn;
    logic [4:0]  fld_b;
    logic [4:0]  fld_e;
    logic [2:0]  creg;
    logic        creg_z;
  } fpo_req_s;

  typedef logic [7:0][31:0] fpo_creg_t;

  typedef struct packed {
    logic        valid;
    logic        exec;
    logic        sat;
    logic [39:0] res;
  } fpo_rsp_s;

  typedef struct packed {
    fpo_rsp_s rsp;
  } fpo_state_s;

endpackage : fpo_pkg

// >>> design/fpo_leftmost_search.sv
/*
  Leftmost bit search: counts the bits above the first bit, from the top,
  that equals the wanted value; returns the width when none matches.
  Purely combinational; the caller registers the count.
*/
`timescale 1ns/1ps
`include "fpo_params.svh"
module fpo_leftmost_search #(
  parameter int W = 32
) (
  input  wire logic [W-1:0]           x_i,
  input  wire logic                   want_i,
  output logic      [`FPO_CNT_W-1:0]  cnt_o
);
  logic found;

  always_comb begin
    found = 1'b0;
    cnt_o = `FPO_CNT_W'(W);
    for (int i = W - 1; i >= 0; i--) begin
      if (!found && x_i[i] == want_i) begin
        found = 1'b1;
        cnt_o = `FPO_CNT_W'(W - 1 - i);
      end
    end
  end
endmodule : fpo_leftmost_search

// >>> design/fpo_shift.sv
/*
  Two-stage shifter: left by one amount, then right by another with sign
  or zero fill. Amounts at or above the width fill completely.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
`include "fpo_params.svh"
module fpo_shift #(
  parameter int W = 40
) (
  input  wire logic [W-1:0]          x_i,
  input  wire logic [`FPO_AMT_W-1:0] lsh_i,
  input  wire logic [`FPO_AMT_W-1:0] rsh_i,
  input  wire logic                  arith_i,
  output logic      [W-1:0]          y_o
);
  logic [W-1:0] mid;

  always_comb begin
    mid = x_i << lsh_i;
    if (arith_i) begin
      y_o = W'($signed(mid) >>> rsh_i);
    end else begin
      y_o = mid >> rsh_i;
    end
  end
endmodule : fpo_shift

// >>> design/fpo_core.sv
/*
  Fixed-point primitive datapath: one request per cycle, result registered
  one edge later. Word results sit in the low 32 bits, upper bits zero, except MV, which passes the whole 40-bit operand.
  Assumes the decoder supplies operands, the condition register values and
  the address mode entry of the base register, all synchronous to clk_i.
*/
`timescale 1ns/1ps
`include "fpo_params.svh"
module fpo_core (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire fpo_pkg::fpo_req_s req_i,
  input  wire fpo_pkg::fpo_amr_s address_mode_register_i,
  input  wire fpo_pkg::fpo_creg_t cond_regs_i,
  output fpo_pkg::fpo_rsp_s      rsp_o
);
  localparam int LW = `FPO_LONG_W;
  localparam int WW = `FPO_WORD_W;
  localparam int HW = `FPO_HALF_W;
  localparam int CW = `FPO_CST_W;
  localparam int AW = `FPO_AMT_W;
  localparam logic [LW-WW-1:0] UPZ = '0;

  fpo_pkg::fpo_state_s st_q;
  fpo_pkg::fpo_state_s st_d;

  logic [LW-1:0]     a;
  logic [LW-1:0]     xb;
  logic [HW-1:0]     hb;
  logic [LW-1:0]     b;
  logic [WW-1:0]     cv;
  logic              exec;
  logic [LW-1:0]     sh_in;
  logic [AW-1:0]     sh_l;
  logic [AW-1:0]     sh_r;
  logic              sh_ar;
  logic [LW-1:0]     sh_out;
  logic [WW-1:0]     ext_out;
  logic [38:0]       nrm_in;
  logic              nrm_want;
  logic [AW-1:0]     srch_cnt;
  logic [AW-1:0]     nrm_cnt;
  logic [WW-1:0]     fmask;
  logic [LW:0]       sat_r;
  logic [LW:0]       abs_r;
  logic [WW-1:0]     chk_sum;
  logic [WW-1:0]     chk_dif;

  // Returns {overflow, result}; the width follows the long flag
  function automatic logic [LW:0] sat_op(input logic [LW-1:0] x,
                                         input logic [LW-1:0] y,
                                         input logic          sub,
                                         input logic          lng);
    logic [LW:0] s;
    logic [WW:0] w;
    s = sub ? {x[LW-1], x} - {y[LW-1], y} : {x[LW-1], x} + {y[LW-1], y};
    w = sub ? {x[WW-1], x[WW-1:0]} - {y[WW-1], y[WW-1:0]}
            : {x[WW-1], x[WW-1:0]} + {y[WW-1], y[WW-1:0]};
    if (lng) begin
      if (s[LW] != s[LW-1]) begin
        return {1'b1, s[LW] ? `FPO_LONG_MIN : `FPO_LONG_MAX};
      end
      return {1'b0, s[LW-1:0]};
    end
    if (w[WW] != w[WW-1]) begin
      return {1'b1, w[WW] ? `FPO_WORD_MIN : `FPO_WORD_MAX};
    end
    return {1'b0, UPZ, w[WW-1:0]};
  endfunction : sat_op

  // Circular mode keeps the bits above the block and wraps inside it
  function automatic logic [WW-1:0] addr_op(input logic [WW-1:0]     base,
                                            input logic [WW-1:0]     off,
                                            input logic              sub,
                                            input fpo_pkg::fpo_amr_s m);
    logic [WW-1:0] sum;
    logic [WW:0]   msk;
    sum = sub ? base - off : base + off;
    msk = ((WW+1)'(1) << ({1'b0, m.blk} + 6'h01)) - (WW+1)'(1);
    if (m.mode == fpo_pkg::AM_CIRC) begin
      return (base & ~msk[WW-1:0]) | (sum & msk[WW-1:0]);
    end
    return sum;
  endfunction : addr_op

  // Operand selection
  always_comb begin
    a  = req_i.src1;
    xb = req_i.use_cross ? req_i.cross2 : req_i.own2;
    hb = req_i.half_hi ? xb[2*HW-1:HW] : xb[HW-1:0];
    case (req_i.src2)
      fpo_pkg::SRC_HALF: begin
        b = {{(LW-HW){req_i.half_sgn & hb[HW-1]}}, hb};
      end
      fpo_pkg::SRC_CST: begin
        b = {{(LW-CW){req_i.cst_sgn & req_i.cst[CW-1]}}, req_i.cst};
      end
      default: begin
        b = xb;
      end
    endcase
  end

  // Creg zero means unconditional; others pick a register value
  always_comb begin
    cv   = cond_regs_i[req_i.creg];
    exec = (req_i.creg == `FPO_CREG_NONE) ||
           (req_i.creg_z ? (cv == '0) : (cv != '0));
  end

  // Shared shifter for word and long shifts
  always_comb begin
    if (req_i.long_op) begin
      sh_in = a;
    end else if (req_i.op == fpo_pkg::OP_SHR) begin
      sh_in = {{(LW-WW){a[WW-1]}}, a[WW-1:0]};
    end else begin
      sh_in = {UPZ, a[WW-1:0]};
    end
    sh_l  = (req_i.op == fpo_pkg::OP_SHL) ? b[AW-1:0] : '0;
    sh_r  = (req_i.op == fpo_pkg::OP_SHL) ? '0 : b[AW-1:0];
    sh_ar = (req_i.op == fpo_pkg::OP_SHR);
  end

  fpo_shift #(
    .W (LW)
  ) u_shift (
    .x_i     (sh_in),
    .lsh_i   (sh_l),
    .rsh_i   (sh_r),
    .arith_i (sh_ar),
    .y_o     (sh_out)
  );

  fpo_shift #(
    .W (WW)
  ) u_extract (
    .x_i     (a[WW-1:0]),
    .lsh_i   ({1'b0, req_i.fld_b}),
    .rsh_i   ({1'b0, req_i.fld_e}),
    .arith_i (req_i.op == fpo_pkg::OP_EXT),
    .y_o     (ext_out)
  );

  fpo_leftmost_search #(
    .W (WW)
  ) u_search (
    .x_i    (b[WW-1:0]),
    .want_i (req_i.op == fpo_pkg::OP_LEFTMOST_ONE_SEARCH),
    .cnt_o  (srch_cnt)
  );

  // Word padding is the opposite of the sign so the count stops at 31
  always_comb begin
    if (req_i.long_op) begin
      nrm_in   = a[LW-2:0];
      nrm_want = ~a[LW-1];
    end else begin
      nrm_in   = {a[WW-2:0], {(LW-WW){~a[WW-1]}}};
      nrm_want = ~a[WW-1];
    end
  end

  fpo_leftmost_search #(
    .W (LW-1)
  ) u_norm (
    .x_i    (nrm_in),
    .want_i (nrm_want),
    .cnt_o  (nrm_cnt)
  );

  // Mask of bits fld_b..fld_e; empty when the begin is above the end
  always_comb begin
    fmask = ({WW{1'b1}} << req_i.fld_b) & ({WW{1'b1}} >> (5'h1F - req_i.fld_e));
    sat_r = sat_op(a, b, (req_i.op == fpo_pkg::OP_SSUB), req_i.long_op);
    abs_r = sat_op('0, a, 1'b1, req_i.long_op);
  end

  always_comb begin
    st_d           = st_q;
    st_d.rsp.valid = req_i.valid;
    st_d.rsp.exec  = req_i.valid & exec;
    if (req_i.valid) begin
      st_d.rsp.sat = 1'b0;
    end
    if (req_i.valid && exec) begin
      case (req_i.op)
        fpo_pkg::OP_ADD: begin
          st_d.rsp.res = req_i.long_op ? a + b : {UPZ, a[WW-1:0] + b[WW-1:0]};
        end
        fpo_pkg::OP_SUB: begin
          st_d.rsp.res = req_i.long_op ? a - b : {UPZ, a[WW-1:0] - b[WW-1:0]};
        end
        fpo_pkg::OP_SADD, fpo_pkg::OP_SSUB: begin
          st_d.rsp.res = sat_r[LW-1:0];
          st_d.rsp.sat = sat_r[LW];
        end
        fpo_pkg::OP_ADDA: begin
          st_d.rsp.res = {UPZ, addr_op(a[WW-1:0], b[WW-1:0], 1'b0,
                                       address_mode_register_i)};
        end
        fpo_pkg::OP_SUBA: begin
          st_d.rsp.res = {UPZ, addr_op(a[WW-1:0], b[WW-1:0], 1'b1,
                                       address_mode_register_i)};
        end
        fpo_pkg::OP_AND: st_d.rsp.res = {UPZ, a[WW-1:0] & b[WW-1:0]};
        fpo_pkg::OP_OR:  st_d.rsp.res = {UPZ, a[WW-1:0] | b[WW-1:0]};
        fpo_pkg::OP_XOR: st_d.rsp.res = {UPZ, a[WW-1:0] ^ b[WW-1:0]};
        fpo_pkg::OP_NOT: st_d.rsp.res = {UPZ, ~a[WW-1:0]};
        fpo_pkg::OP_ABS: begin
          // Most negative input saturates rather than staying negative
          if (req_i.long_op ? a[LW-1] : a[WW-1]) begin
            st_d.rsp.res = abs_r[LW-1:0];
            st_d.rsp.sat = abs_r[LW];
          end else begin
            st_d.rsp.res = req_i.long_op ? a : {UPZ, a[WW-1:0]};
          end
        end
        fpo_pkg::OP_CLR: st_d.rsp.res = {UPZ, a[WW-1:0] & ~fmask};
        fpo_pkg::OP_SET: st_d.rsp.res = {UPZ, a[WW-1:0] | fmask};
        fpo_pkg::OP_EXT, fpo_pkg::OP_EXTU: begin
          st_d.rsp.res = {UPZ, ext_out};
        end
        fpo_pkg::OP_SHL, fpo_pkg::OP_SHR, fpo_pkg::OP_SHRU: begin
          st_d.rsp.res = req_i.long_op ? sh_out : {UPZ, sh_out[WW-1:0]};
        end
        fpo_pkg::OP_LEFTMOST_ZERO_SEARCH, fpo_pkg::OP_LEFTMOST_ONE_SEARCH: begin
          st_d.rsp.res = {{(LW-AW){1'b0}}, srch_cnt};
        end
        fpo_pkg::OP_NORM: st_d.rsp.res = {{(LW-AW){1'b0}}, nrm_cnt};
        fpo_pkg::OP_MV:   st_d.rsp.res = b;
        default:          st_d.rsp.res = st_q.rsp.res;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '{rsp: '{valid: 1'b0, exec: 1'b0, sat: 1'b0, res: `FPO_RST_RES}};
    end else begin
      st_q <= st_d;
    end
  end

  assign rsp_o = st_q.rsp;

  // Checks below: helper sums are read only by assertions
  assign chk_sum = a[WW-1:0] + b[WW-1:0];
  assign chk_dif = a[WW-1:0] - b[WW-1:0];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_word_go(fpo_pkg::fpo_op_e o);
    req_i.valid && exec && !req_i.long_op && req_i.op == o;
  endsequence

  a_sadd_pos_clamp: assert property (
    s_word_go(fpo_pkg::OP_SADD) ##0 (!a[WW-1] && !b[WW-1] && chk_sum[WW-1])
    |=> rsp_o.res == `FPO_WORD_MAX && rsp_o.sat && rsp_o.exec)
    else $error("saturating add did not clamp to word max");

  a_ssub_neg_clamp: assert property (
    s_word_go(fpo_pkg::OP_SSUB) ##0 (a[WW-1] && !b[WW-1] && !chk_dif[WW-1])
    |=> rsp_o.res == `FPO_WORD_MIN && rsp_o.sat)
    else $error("saturating subtract did not clamp to word min");

  a_ssub_no_sat: assert property (
    s_word_go(fpo_pkg::OP_SSUB) ##0 (a[WW-1] == b[WW-1])
    |=> !rsp_o.sat && rsp_o.res[WW-1:0] == $past(chk_dif))
    else $error("subtract without overflow was altered");

  a_addr_circ_keep: assert property (
    (req_i.valid && exec && req_i.op == fpo_pkg::OP_ADDA &&
     address_mode_register_i.mode == fpo_pkg::AM_CIRC &&
     address_mode_register_i.blk < 5'h1E)
    |=> (rsp_o.res[WW-1:0] >> ($past(address_mode_register_i.blk) + 5'h01)) ==
        ($past(a[WW-1:0]) >> ($past(address_mode_register_i.blk) + 5'h01)))
    else $error("circular address add changed bits above the block");

  a_cond_skip_hold: assert property (
    (req_i.valid && req_i.creg != `FPO_CREG_NONE && req_i.creg_z && cv != '0)
    |=> rsp_o.valid && !rsp_o.exec && $stable(rsp_o.res))
    else $error("false condition still wrote a result");

  a_clr_end_bit: assert property (
    s_word_go(fpo_pkg::OP_CLR) ##0 (req_i.fld_b <= req_i.fld_e)
    |=> rsp_o.res[$past(req_i.fld_e)] == 1'b0 && rsp_o.res[$past(req_i.fld_b)] == 1'b0)
    else $error("field clear left a bit set");

  a_set_begin_bit: assert property (
    s_word_go(fpo_pkg::OP_SET) ##0 (req_i.fld_b <= req_i.fld_e)
    |=> rsp_o.res[$past(req_i.fld_b)] && rsp_o.res[$past(req_i.fld_e)])
    else $error("field set left a bit clear");

  a_shr_sign_fill: assert property (
    s_word_go(fpo_pkg::OP_SHR) ##0 (a[WW-1] && b[AW-1:0] != '0)
    |=> rsp_o.res[WW-1:WW-2] == 2'h3)
    else $error("arithmetic shift did not replicate sign");

  a_shru_zero_fill: assert property (
    s_word_go(fpo_pkg::OP_SHRU) ##0 (b[AW-1:0] != '0)
    |=> rsp_o.res[WW-1] == 1'b0)
    else $error("logical shift did not fill with zero");

  a_search_hit: assert property (
    s_word_go(fpo_pkg::OP_LEFTMOST_ONE_SEARCH) ##0 (b[WW-1:0] != '0)
    |=> rsp_o.res < LW'(WW) && $past(b[WW-1:0]) >> (WW - 1 - rsp_o.res[4:0]) == 32'h1)
    else $error("leftmost one search missed the first one");
endmodule : fpo_core

// >>> tb/fpo_src_model.sv
/*
  Stand-in for the instruction decoder and register file: presents one
  request a cycle, the base register's address mode and the condition
  registers. Assumes its tasks are called just after a rising clk_i edge.
*/
`timescale 1ns/1ps
module fpo_src_model (
  output fpo_pkg::fpo_req_s  req_o,
  output fpo_pkg::fpo_amr_s  amr_o,
  output fpo_pkg::fpo_creg_t creg_o
);
  initial begin
    req_o  = '0;
    amr_o  = '0;
    creg_o = '0;
  end

  task automatic send(input fpo_pkg::fpo_req_s r, input fpo_pkg::fpo_amr_s m);
    req_o = r;
    amr_o = m;
  endtask : send

  // Released operands show the inverse, so a stale value cannot pass
  task automatic idle();
    fpo_pkg::fpo_req_s r;
    r       = ~req_o;
    r.valid = 1'b0;
    req_o   = r;
  endtask : idle

  task automatic set_creg(input int i, input logic [31:0] v);
    creg_o[i] = v;
  endtask : set_creg
endmodule : fpo_src_model

// >>> tb/fpo_core_bench.sv
/*
  Self-checking bench for the fixed-point primitive datapath.
  Assumes the source model drives all inputs except clock and reset.
*/
`timescale 1ns/1ps
module fpo_core_bench;
  localparam fpo_pkg::fpo_amr_s CIRC = '{mode: fpo_pkg::AM_CIRC, blk: 5'h03};
  logic               clk_i;
  logic               rst_i;
  fpo_pkg::fpo_req_s  req;
  fpo_pkg::fpo_amr_s  address_mode_register;
  fpo_pkg::fpo_creg_t cregs;
  fpo_pkg::fpo_rsp_s  rsp;
  int                 miscompares;
  int                 cmp_count;
  int                 cycles;
  logic [39:0]        last_res;

  fpo_src_model src (.req_o(req), .amr_o(address_mode_register), .creg_o(cregs));
  fpo_core uut (
    .clk_i                   (clk_i),
    .rst_i                   (rst_i),
    .req_i                   (req),
    .address_mode_register_i (address_mode_register),
    .cond_regs_i             (cregs),
    .rsp_o                   (rsp)
  );

  initial clk_i = 1'b0;
  always #12.5 clk_i = ~clk_i;

  // Whole run needs about 70 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [39:0] exp, input logic [39:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic fpo_pkg::fpo_req_s mk(input fpo_pkg::fpo_op_e op, input logic lng,
                                           input logic [39:0] a, input logic [39:0] b);
    fpo_pkg::fpo_req_s r;
    r         = '0;
    r.valid   = 1'b1;
    r.op      = op;
    r.long_op = lng;
    r.src1    = a;
    r.own2    = b;
    return r;
  endfunction : mk

  // One request, answer looked at one edge later
  task automatic run(input fpo_pkg::fpo_req_s r, input logic [39:0] exp, input logic st,
                     input fpo_pkg::fpo_amr_s m = '0, input logic ex = 1'b1);
    src.send(r, m);
    @(posedge clk_i);
    #1;
    check("valid", 40'(1'b1), 40'(rsp.valid));
    check("exec", 40'(ex), 40'(rsp.exec));
    check("sat", 40'(st), 40'(rsp.sat));
    check("res", exp, rsp.res);
    last_res = exp;
  endtask : run

  // Plain two-operand request on the own-side register path
  task automatic op2(input fpo_pkg::fpo_op_e op, input logic lng, input logic [39:0] a,
                     input logic [39:0] b, input logic [39:0] exp, input logic st);
    run(mk(op, lng, a, b), exp, st);
  endtask : op2

  task automatic t_sat();
    op2(fpo_pkg::OP_SADD, 1'b0, 40'h7FFFFFFF, 40'h1, 40'h7FFFFFFF, 1'b1);
    op2(fpo_pkg::OP_SADD, 1'b0, 40'h80000000, 40'hFFFFFFFF, 40'h80000000, 1'b1);
    op2(fpo_pkg::OP_SSUB, 1'b0, 40'h80000000, 40'h1, 40'h80000000, 1'b1);
    op2(fpo_pkg::OP_SSUB, 1'b0, 40'h5, 40'h3, 40'h2, 1'b0);
    op2(fpo_pkg::OP_SSUB, 1'b1, 40'h8000000000, 40'h1, 40'h8000000000, 1'b1);
    op2(fpo_pkg::OP_SADD, 1'b1, 40'h7FFFFFFFFF, 40'h1, 40'h7FFFFFFFFF, 1'b1);
    op2(fpo_pkg::OP_ADD, 1'b1, 40'hFFFFFFFFFF, 40'h1, 40'h0, 1'b0);
    op2(fpo_pkg::OP_SADD, 1'b0, 40'h7FFFFFFF, 40'h7FFFFFFF, 40'h7FFFFFFF, 1'b1);
    src.idle();
    @(posedge clk_i);
    #1;
    check("idle valid", 40'h0, 40'(rsp.valid));
    check("idle exec", 40'h0, 40'(rsp.exec));
    check("idle res", last_res, rsp.res);
  endtask : t_sat

  // Block of 16 bytes: only the low four address bits wrap
  task automatic t_addr();
    run(mk(fpo_pkg::OP_ADDA, 1'b0, 40'h10C, 40'h8), 40'h114, 1'b0);
    run(mk(fpo_pkg::OP_ADDA, 1'b0, 40'h10C, 40'h8), 40'h104, 1'b0, CIRC);
    run(mk(fpo_pkg::OP_SUBA, 1'b0, 40'h104, 40'h8), 40'h10C, 1'b0, CIRC);
    run(mk(fpo_pkg::OP_SUBA, 1'b0, 40'h104, 40'h8), 40'hFC, 1'b0);
  endtask : t_addr

  task automatic t_cond();
    fpo_pkg::fpo_req_s r;
    logic              go;
    for (int i = 0; i < 8; i++) begin
      src.set_creg(i, (i % 2 == 1) ? 32'h0 : 32'h000000A5);
    end
    for (int i = 0; i < 8; i++) begin
      r        = mk(fpo_pkg::OP_ADD, 1'b0, 40'(i + 16), 40'h0);
      r.creg   = 3'(i);
      r.creg_z = 1'b1;
      go       = (i % 2 == 1) || (i == 0);
      run(r, go ? 40'(i + 16) : last_res, 1'b0, '0, go);
    end
    // Register 7 holds zero, so asking for nonzero must skip
    r.creg_z = 1'b0;
    r.src1   = 40'h55;
    run(r, 40'h17, 1'b0, '0, 1'b0);
    r.creg = 3'h2;
    r.src1 = 40'h2A;
    run(r, 40'h2A, 1'b0);
  endtask : t_cond

  task automatic t_bits();
    fpo_pkg::fpo_req_s r;
    r       = mk(fpo_pkg::OP_CLR, 1'b0, 40'hFFFFFFFF, 40'h0);
    r.fld_b = 5'h04;
    r.fld_e = 5'h0B;
    run(r, 40'hFFFFF00F, 1'b0);
    r.op   = fpo_pkg::OP_SET;
    r.src1 = 40'h0;
    run(r, 40'h00000FF0, 1'b0);
    r.fld_b = 5'h0C;
    run(r, 40'h0, 1'b0);
    r.op    = fpo_pkg::OP_EXT;
    r.src1  = 40'h0000F000;
    r.fld_b = 5'h10;
    r.fld_e = 5'h1C;
    run(r, 40'hFFFFFFFF, 1'b0);
    r.op = fpo_pkg::OP_EXTU;
    run(r, 40'h0000000F, 1'b0);
  endtask : t_bits

  task automatic t_shift();
    fpo_pkg::fpo_req_s r;
    r      = mk(fpo_pkg::OP_SHR, 1'b0, 40'h0080000000, 40'h0);
    r.src2 = fpo_pkg::SRC_CST;
    r.cst  = 5'h04;
    run(r, 40'hF8000000, 1'b0);
    r.op = fpo_pkg::OP_SHRU;
    run(r, 40'h08000000, 1'b0);
    op2(fpo_pkg::OP_SHR, 1'b1, 40'h8000000000, 40'h4, 40'hF800000000, 1'b0);
    op2(fpo_pkg::OP_SHRU, 1'b1, 40'h8000000000, 40'h4, 40'h0800000000, 1'b0);
    op2(fpo_pkg::OP_SHL, 1'b0, 40'h1, 40'h1F, 40'h80000000, 1'b0);
    op2(fpo_pkg::OP_SHL, 1'b0, 40'h1, 40'h20, 40'h0, 1'b0);
    op2(fpo_pkg::OP_SHL, 1'b1, 40'h1, 40'h27, 40'h8000000000, 1'b0);
  endtask : t_shift

  task automatic t_search();
    op2(fpo_pkg::OP_LEFTMOST_ONE_SEARCH, 1'b0, 40'h0, 40'h00F00000, 40'h8, 1'b0);
    op2(fpo_pkg::OP_LEFTMOST_ZERO_SEARCH, 1'b0, 40'h0, 40'hFFF00000, 40'hC, 1'b0);
    op2(fpo_pkg::OP_LEFTMOST_ONE_SEARCH, 1'b0, 40'h0, 40'h0, 40'h20, 1'b0);
    op2(fpo_pkg::OP_NORM, 1'b0, 40'h00001000, 40'h0, 40'h12, 1'b0);
    op2(fpo_pkg::OP_NORM, 1'b0, 40'hFFFFFFFF, 40'h0, 40'h1F, 1'b0);
    op2(fpo_pkg::OP_NORM, 1'b1, 40'h1, 40'h0, 40'h26, 1'b0);
  endtask : t_search

  task automatic half(input logic hi, input logic sg, input logic [39:0] v,
                      input logic [39:0] exp);
    fpo_pkg::fpo_req_s r;
    r          = mk(fpo_pkg::OP_ADD, 1'b0, 40'h0, v);
    r.src2     = fpo_pkg::SRC_HALF;
    r.half_hi  = hi;
    r.half_sgn = sg;
    run(r, exp, 1'b0);
  endtask : half

  task automatic t_operand();
    fpo_pkg::fpo_req_s r;
    half(1'b1, 1'b1, 40'h0080017FFF, 40'hFFFF8001);
    half(1'b1, 1'b0, 40'h0080017FFF, 40'h00008001);
    half(1'b0, 1'b1, 40'h0080017FFF, 40'h00007FFF);
    half(1'b0, 1'b1, 40'h0000008000, 40'hFFFF8000);
    r        = mk(fpo_pkg::OP_ADD, 1'b0, 40'h0, 40'h3);
    r.cross2 = 40'h7;
    run(r, 40'h3, 1'b0);
    r.use_cross = 1'b1;
    run(r, 40'h7, 1'b0);
    r      = mk(fpo_pkg::OP_ADD, 1'b0, 40'hA, 40'h0);
    r.src2 = fpo_pkg::SRC_CST;
    r.cst  = 5'h1F;
    run(r, 40'h29, 1'b0);
    r.cst_sgn = 1'b1;
    run(r, 40'h9, 1'b0);
  endtask : t_operand

  // NOT and ABS get the same value in both operands
  task automatic t_logic();
    op2(fpo_pkg::OP_AND, 1'b0, 40'hF0F0F0F0, 40'hFF00FF00, 40'hF000F000, 1'b0);
    op2(fpo_pkg::OP_OR, 1'b0, 40'hF0F0F0F0, 40'hFF00FF00, 40'hFFF0FFF0, 1'b0);
    op2(fpo_pkg::OP_XOR, 1'b0, 40'hF0F0F0F0, 40'hFF00FF00, 40'h0FF00FF0, 1'b0);
    op2(fpo_pkg::OP_NOT, 1'b0, 40'hF0F0F0F0, 40'hF0F0F0F0, 40'h0F0F0F0F, 1'b0);
    op2(fpo_pkg::OP_SUB, 1'b0, 40'h3, 40'h5, 40'hFFFFFFFE, 1'b0);
    op2(fpo_pkg::OP_SUB, 1'b1, 40'h3, 40'h5, 40'hFFFFFFFFFE, 1'b0);
    op2(fpo_pkg::OP_MV, 1'b1, 40'h0, 40'hA5A5A5A5A5, 40'hA5A5A5A5A5, 1'b0);
    op2(fpo_pkg::OP_ABS, 1'b0, 40'hFFFFFFFB, 40'hFFFFFFFB, 40'h5, 1'b0);
    op2(fpo_pkg::OP_ABS, 1'b0, 40'h80000000, 40'h80000000, 40'h7FFFFFFF, 1'b1);
  endtask : t_logic

  // Reset in mid-run must drop a held result and a standing sat flag
  task automatic t_reset();
    rst_i = 1'b1;
    @(posedge clk_i);
    #1;
    check("mid reset valid", 40'h0, 40'(rsp.valid));
    check("mid reset sat", 40'h0, 40'(rsp.sat));
    check("mid reset res", 40'h0, rsp.res);
    rst_i = 1'b0;
    op2(fpo_pkg::OP_ADD, 1'b0, 40'h1, 40'h2, 40'h3, 1'b0);
  endtask : t_reset

  initial begin
    rst_i       = 1'b1;
    miscompares = 0;
    cmp_count   = 0;
    cycles      = 0;
    last_res    = '0;
    repeat (12) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    check("reset valid", 40'h0, 40'(rsp.valid));
    check("reset res", 40'h0, rsp.res);
    t_sat();
    t_addr();
    t_cond();
    t_bits();
    t_shift();
    t_search();
    t_operand();
    t_logic();
    t_reset();
    finish_test();
  end
endmodule : fpo_core_bench
